//--- hdl/rie_edge_det.sv
`timescale 1ns/1ns
module rie_edge_det #(
  parameter int W = 4
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic [W-1:0] pin, // raw pins, idle high
  input wire logic [W-1:0] use_int, // pin assigned to interrupt input
  input wire logic [W-1:0] rise_sel, // 1 rising, 0 falling
  output logic [W-1:0] edge_seen // one-cycle pulse per edge
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] prev;
  } rie_edge_st_t;

  rie_edge_st_t s_ff;
  rie_edge_st_t nxt_s;
  logic [W-1:0] gated;

  // a pin not in interrupt use reads idle high, so changing its mode with
  // the pin low looks like a falling edge and can raise its flag
  assign gated = (use_int & s_ff.s2) | ~use_int;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = pin;
    nxt_s.s2 = s_ff.s1;
    nxt_s.prev = gated;
    edge_seen = (rise_sel & gated & ~s_ff.prev) | (~rise_sel & ~gated & s_ff.prev);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{s1: '1, s2: '1, prev: '1};
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // rie_edge_det

//--- hdl/rie_pkg.sv
package rie_pkg;
  // ****************************************
  // apb register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_REQ_EDGE = 8'h00;
  localparam logic [7:0] OFS_WAKE_EDGE = 8'h04;
  localparam logic [7:0] OFS_PORT_MODE_1 = 8'h08;
  localparam logic [7:0] OFS_PORT_MODE_5 = 8'h0c;
  localparam logic [7:0] OFS_REQ_FLAG = 8'h10;
  localparam logic [7:0] OFS_WAKE_FLAG = 8'h14;
  localparam logic [7:0] OFS_REQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_PERIPH_ENABLE = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_VECTOR = 8'h24;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int NUM_REQ = 4;
  localparam int NUM_WAKE = 6;
  localparam int BIT_WAKE_EN = 5;
  localparam int BIT_DXFER = 7;
  localparam int SRC_W = 4;
  localparam int SRC_NMI = 0;
  localparam int SRC_ABRK = 1;
  localparam int SRC_REQ0 = 2;
  localparam int SRC_WAKE = 6;
  localparam int SRC_DXFER = 7;
  localparam int SRC_PERIPH0 = 8;

  // ****************************************
  // vectors and reset values
  // ****************************************
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] INT_VECTOR_BASE = 16'h0008;
  localparam logic [3:0] ZERO4 = 4'h0;
  localparam logic [5:0] ZERO6 = 6'h00;

  // ****************************************
  // sequence lengths in states (one state = one pclk)
  // ****************************************
  localparam int RESET_MIN_CYCLES = 10;
  localparam logic [3:0] RST_VEC_STATES = 4'h2;
  localparam logic [3:0] STACK_STATES = 4'h4;
  localparam logic [3:0] VEC_STATES = 4'h2;
  localparam logic [3:0] IFETCH_STATES = 4'h4;
  localparam logic [3:0] INTPROC_STATES = 4'h4;

  typedef enum logic [2:0] {
    PH_RST_VEC, PH_FIRST, PH_RUN, PH_STACK, PH_VEC, PH_IFETCH, PH_INTPROC
  } rie_phase_t;
endpackage

//--- hdl/rie_prio.sv
`timescale 1ns/1ns
module rie_prio
  import rie_pkg::*;
#(
  parameter int NS = 12
) (
  input wire logic [NS-1:0] req, // forwarded requests, bit 0 highest
  output logic any, // some request present
  output logic [SRC_W-1:0] idx // winning source
);
  function automatic logic [SRC_W-1:0] first_set(input logic [NS-1:0] v);
    logic [SRC_W-1:0] r;
    r = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = SRC_W'(i);
      end
    end
    return r;
  endfunction

  assign any = |req;
  assign idx = first_set(req);
endmodule // rie_prio

//--- hdl/rie_seq.sv
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
// How it works
// - during reset everything halts and all state and peripheral registers initialise.
// - on release set the mask, fetch the vector at address zero, start there.
// - a falling edge on the non-maskable pin raises the top request, never masked.
// - four request pins, own vectors, each with its own rising/falling edge select.
// - request pin edge in interrupt mode sets its flag; enable masks; acceptance sets mask.
// - six wake pins share one vector, each with its own edge select.
// - wake pin edge sets its wake flag; one shared wake enable masks all six.
// - peripheral sources have flag and enable; clear enable masks; acceptance sets mask.
// - the sleep direct-transfer flag and enable live in request flag/enable registers.
// - only the non-maskable and break sources or enabled ones are forwarded to arbitration.
// - with several requests only the highest one is presented; others stay pending.
// - non-maskable and break requests ignore mask; others need mask clear.
// - entry waits for instruction end, then pushes counter and condition codes.
// - after stacking set the mask; return restores the saved mask value.
// - form the accepted source's vector address, load it, start the handler.
// - waiting for the current instruction takes one to thirteen states.
// - entry takes four stacking, two vector, four fetch, four internal states.
// - right after reset every request is blocked until the first instruction ends.
// - word and stack addresses always have bit zero forced to zero.
// - rewriting a pin's mode may set its request flag.
// - request and wake flags clear only by software writing zero.
module rie_seq
  import rie_pkg::*;
#(
  parameter int NP = 4
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic nmi_n, // non-maskable pin
  input wire logic [NUM_REQ-1:0] ext_request_line_n, // request pins 3..0
  input wire logic [NUM_WAKE-1:0] wake_line_n, // wake pins 5..0
  input wire logic abrk_req, // break unit request level
  input wire logic sleep_xfer, // direct-transfer pulse from sleep
  input wire logic [NP-1:0] periph_flag, // peripheral request flags
  input wire logic instr_done, // cpu finished current instruction
  input wire logic rte_done, // cpu executed return from handler
  input wire logic rte_mask, // mask value popped by return
  input wire logic [15:0] cpu_pc, // return address to push
  input wire logic [7:0] cpu_ccr, // condition codes to push
  input wire logic [15:0] stack_pointer, // current stack pointer
  output logic cpu_halt, // cpu must not execute
  output logic periph_rst_n, // peripheral reset, low
  output logic cond_code_mask, // mask bit of cond_code_reg
  output logic vec_fetch, // vector read strobe
  output logic [15:0] vector_addr, // vector address, even
  output logic load_pc, // one-cycle pulse: load pc from vector
  output logic stack_push, // stack write strobe
  output logic [15:0] stack_addr, // stack word address, even
  output logic [15:0] push_data // word pushed
);
  localparam int NS = SRC_PERIPH0 + NP;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    rie_phase_t ph;
    logic [3:0] cnt;
    logic mask;
    logic [NUM_REQ-1:0] redge;
    logic [NUM_WAKE-1:0] wedge;
    logic [NUM_REQ-1:0] port_mode_reg_1;
    logic [NUM_WAKE-1:0] port_mode_reg_5;
    logic [NUM_REQ-1:0] rflag;
    logic dflag;
    logic [NUM_WAKE-1:0] wflag;
    logic [NUM_REQ-1:0] ren;
    logic den;
    logic wen;
    logic [NP-1:0] pen;
    logic nmi;
    logic [SRC_W-1:0] src;
    logic rdy;
    logic err;
    logic [31:0] rdata;
    logic halt;
    logic prst_n;
    logic vfetch;
    logic [15:0] vaddr;
    logic ldpc;
    logic push;
    logic [15:0] saddr;
    logic [15:0] pdata;
  } rie_seq_st_t;

  rie_seq_st_t s_ff;
  rie_seq_st_t nxt_s;

  logic [NUM_REQ-1:0] req_edge;
  logic [NUM_WAKE-1:0] wake_edge;
  logic nmi_edge;
  logic [NS-1:0] fwd;
  logic any_req;
  logic [SRC_W-1:0] win;
  logic wr;
  logic rd;
  logic take;
  logic nonmask;

  // ****************************************
  // pin edge detection
  // ****************************************
  rie_edge_det #(.W(NUM_REQ)) u_req_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_request_line_n),
    .use_int(s_ff.port_mode_reg_1),
    .rise_sel(s_ff.redge),
    .edge_seen(req_edge)
  );

  rie_edge_det #(.W(NUM_WAKE)) u_wake_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(wake_line_n),
    .use_int(s_ff.port_mode_reg_5),
    .rise_sel(s_ff.wedge),
    .edge_seen(wake_edge)
  );

  rie_edge_det #(.W(1)) u_nmi_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(nmi_n),
    .use_int(1'b1),
    .rise_sel(1'b0),
    .edge_seen(nmi_edge)
  );

  // ****************************************
  // forwarding and arbitration
  // ****************************************
  always_comb begin
    fwd = '0;
    fwd[SRC_NMI] = s_ff.nmi;
    fwd[SRC_ABRK] = abrk_req;
    fwd[SRC_REQ0 +: NUM_REQ] = s_ff.rflag & s_ff.ren;
    fwd[SRC_WAKE] = (|s_ff.wflag) & s_ff.wen;
    fwd[SRC_DXFER] = s_ff.dflag & s_ff.den;
    fwd[SRC_PERIPH0 +: NP] = periph_flag & s_ff.pen;
  end

  rie_prio #(.NS(NS)) u_prio (
    .req(fwd),
    .any(any_req),
    .idx(win)
  );

  assign nonmask = (win == SRC_W'(SRC_NMI)) || (win == SRC_W'(SRC_ABRK));
  // acceptance only between instructions, never before the first one
  // the cpu's own instruction length sets the one-to-thirteen state wait
  assign take = (s_ff.ph == PH_RUN) && instr_done && any_req
    && (nonmask || !s_ff.mask);
  assign wr = psel && penable && s_ff.rdy && pwrite;
  assign rd = psel && !penable && !pwrite;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ldpc = 1'b0;
    nxt_s.halt = 1'b0;
    nxt_s.prst_n = 1'b1;
    // one wait state: ready rises in the access phase's second cycle
    nxt_s.rdy = psel && penable && !s_ff.rdy;
    nxt_s.err = 1'b0;
    if (psel && penable && !s_ff.rdy) begin
      nxt_s.err = !(paddr inside {OFS_REQ_EDGE, OFS_WAKE_EDGE, OFS_PORT_MODE_1,
        OFS_PORT_MODE_5, OFS_REQ_FLAG, OFS_WAKE_FLAG, OFS_REQ_ENABLE,
        OFS_PERIPH_ENABLE, OFS_STATUS, OFS_VECTOR});
    end
    if (rd) begin
      case (paddr)
        OFS_REQ_EDGE: nxt_s.rdata = 32'(s_ff.redge);
        OFS_WAKE_EDGE: nxt_s.rdata = 32'(s_ff.wedge);
        OFS_PORT_MODE_1: nxt_s.rdata = 32'(s_ff.port_mode_reg_1);
        OFS_PORT_MODE_5: nxt_s.rdata = 32'(s_ff.port_mode_reg_5);
        OFS_REQ_FLAG: nxt_s.rdata = 32'({s_ff.dflag, 3'h0, s_ff.rflag});
        OFS_WAKE_FLAG: nxt_s.rdata = 32'(s_ff.wflag);
        OFS_REQ_ENABLE: nxt_s.rdata = 32'({s_ff.den, 1'b0, s_ff.wen, 1'b0, s_ff.ren});
        OFS_PERIPH_ENABLE: nxt_s.rdata = 32'(s_ff.pen);
        OFS_STATUS: nxt_s.rdata = 32'({s_ff.ph, s_ff.mask, any_req, win});
        OFS_VECTOR: nxt_s.rdata = 32'(s_ff.vaddr);
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end

    // flags: writing 0 clears, writing 1 keeps; a same-cycle edge wins
    if (wr && paddr == OFS_REQ_FLAG) begin
      nxt_s.rflag = s_ff.rflag & pwdata[NUM_REQ-1:0];
      nxt_s.dflag = s_ff.dflag & pwdata[BIT_DXFER];
    end
    if (wr && paddr == OFS_WAKE_FLAG) begin
      nxt_s.wflag = s_ff.wflag & pwdata[NUM_WAKE-1:0];
    end
    nxt_s.rflag = nxt_s.rflag | req_edge;
    nxt_s.wflag = nxt_s.wflag | wake_edge;
    nxt_s.dflag = nxt_s.dflag | sleep_xfer;
    nxt_s.nmi = (s_ff.nmi && !(take && win == SRC_W'(SRC_NMI))) || nmi_edge;

    if (wr) begin
      case (paddr)
        OFS_REQ_EDGE: nxt_s.redge = pwdata[NUM_REQ-1:0];
        OFS_WAKE_EDGE: nxt_s.wedge = pwdata[NUM_WAKE-1:0];
        OFS_PORT_MODE_1: nxt_s.port_mode_reg_1 = pwdata[NUM_REQ-1:0];
        OFS_PORT_MODE_5: nxt_s.port_mode_reg_5 = pwdata[NUM_WAKE-1:0];
        OFS_REQ_ENABLE: begin
          nxt_s.ren = pwdata[NUM_REQ-1:0];
          nxt_s.wen = pwdata[BIT_WAKE_EN];
          nxt_s.den = pwdata[BIT_DXFER];
        end
        OFS_PERIPH_ENABLE: nxt_s.pen = pwdata[NP-1:0];
        default: ;
      endcase
    end

    // ****************************************
    // exception sequencer
    // ****************************************
    if (rte_done) begin
      nxt_s.mask = rte_mask;
    end
    case (s_ff.ph)
      PH_RST_VEC: begin
        nxt_s.mask = 1'b1;
        nxt_s.vaddr = RESET_VECTOR;
        nxt_s.halt = 1'b1;
        if (s_ff.cnt == ZERO4) begin
          nxt_s.ldpc = 1'b1;
          nxt_s.ph = PH_FIRST;
        end else begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end
      end
      PH_FIRST: begin
        if (instr_done) begin
          nxt_s.ph = PH_RUN;
        end
      end
      PH_RUN: begin
        if (take) begin
          nxt_s.ph = PH_STACK;
          nxt_s.cnt = STACK_STATES - 4'h1;
          nxt_s.src = win;
        end
      end
      PH_STACK: begin
        if (s_ff.cnt == ZERO4) begin
          nxt_s.mask = 1'b1;
          nxt_s.ph = PH_VEC;
          nxt_s.cnt = VEC_STATES - 4'h1;
        end else begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end
      end
      PH_VEC: begin
        if (s_ff.cnt == ZERO4) begin
          nxt_s.ldpc = 1'b1;
          nxt_s.ph = PH_IFETCH;
          nxt_s.cnt = IFETCH_STATES - 4'h1;
        end else begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end
      end
      PH_IFETCH: begin
        if (s_ff.cnt == ZERO4) begin
          nxt_s.ph = PH_INTPROC;
          nxt_s.cnt = INTPROC_STATES - 4'h1;
        end else begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end
      end
      PH_INTPROC: begin
        if (s_ff.cnt == ZERO4) begin
          nxt_s.ph = PH_RUN;
        end else begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end
      end
      default: nxt_s.ph = PH_RUN;
    endcase

    nxt_s.push = (nxt_s.ph == PH_STACK);
    nxt_s.vfetch = (nxt_s.ph == PH_VEC) || (s_ff.ph == PH_RST_VEC);
    if (nxt_s.ph == PH_VEC) begin
      nxt_s.vaddr = INT_VECTOR_BASE + {11'h000, nxt_s.src, 1'b0};
    end
    // first two stacking states write the counter, last two the codes
    if (nxt_s.ph == PH_STACK && nxt_s.cnt >= 4'h2) begin
      nxt_s.saddr = {stack_pointer[15:1], 1'b0} - 16'h0002;
      nxt_s.pdata = cpu_pc;
    end else if (nxt_s.ph == PH_STACK) begin
      nxt_s.saddr = {stack_pointer[15:1], 1'b0} - 16'h0004;
      nxt_s.pdata = {cpu_ccr, cpu_ccr};
    end
  end

  // all state initialises under reset, peripherals included via periph_rst_n
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.ph <= PH_RST_VEC;
      s_ff.cnt <= RST_VEC_STATES - 4'h1;
      s_ff.mask <= 1'b1;
      s_ff.halt <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.rdata;
  assign pready = s_ff.rdy;
  assign pslverr = s_ff.err;
  assign cpu_halt = s_ff.halt;
  assign periph_rst_n = s_ff.prst_n;
  assign cond_code_mask = s_ff.mask;
  assign vec_fetch = s_ff.vfetch;
  assign vector_addr = s_ff.vaddr;
  assign load_pc = s_ff.ldpc;
  assign stack_push = s_ff.push;
  assign stack_addr = s_ff.saddr;
  assign push_data = s_ff.pdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_stack;
    stack_push [*4];
  endsequence
  sequence seq_vec;
    vec_fetch [*2];
  endsequence
  sequence seq_tail;
    (!stack_push && !vec_fetch) [*8] ##1 (s_ff.ph == PH_RUN);
  endsequence

  chk_entry_length: assert property ($rose(stack_push)
    |-> seq_stack ##1 seq_vec ##1 seq_tail)
    else $error("entry sequence length wrong");
  chk_nmi_unmasked: assert property (take && win == SRC_W'(SRC_NMI) |=> stack_push)
    else $error("nmi not taken");
  chk_mask_blocks: assert property ((s_ff.ph == PH_RUN) && instr_done
    && s_ff.mask && !nonmask |=> s_ff.ph == PH_RUN)
    else $error("masked request accepted");
  chk_first_block: assert property (s_ff.ph == PH_FIRST |=> !stack_push)
    else $error("request taken before first instruction");
  chk_mask_after: assert property ($rose(vec_fetch) && s_ff.ph == PH_VEC |-> cond_code_mask)
    else $error("mask not set after stacking");
  chk_stack_even: assert property (stack_push |-> !stack_addr[0] && !vector_addr[0])
    else $error("odd word address");
  chk_flag_set: assert property (req_edge[0] |=> s_ff.rflag[0])
    else $error("request flag not set");
  chk_flag_hold: assert property (s_ff.wflag[0]
    && !(wr && paddr == OFS_WAKE_FLAG && !pwdata[0]) |=> s_ff.wflag[0])
    else $error("wake flag lost");
  chk_vector_src: assert property ($rose(vec_fetch) && s_ff.ph == PH_VEC
    |-> vector_addr == INT_VECTOR_BASE + {11'h000, $past(win, 5), 1'b0})
    else $error("vector address mismatch");
  chk_apb_ready: assert property (psel && penable && !pready |=> pready)
    else $error("apb ready late");
endmodule // rie_seq

//--- verif/reset_and_interrupt_exception_seq_test.sv
`timescale 1ns/1ns
module reset_and_interrupt_exception_seq_test;
  import rie_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, nmi_n = 1, abrk_req = 0, sleep_xfer = 0, rte_go = 0;
  logic [3:0] irq_n = 4'hf, periph_flag = 4'h0;
  logic [5:0] wake_n = 6'h3f;
  logic instr_done, rte_done, rte_mask, cpu_halt, periph_rst_n, cond_code_mask;
  logic vec_fetch, load_pc, stack_push;
  logic [15:0] cpu_pc, vector_addr, stack_addr, push_data;
  int mismatches = 0, checks = 0, dones = 0;
  localparam logic [15:0] SP_ODD = 16'h0ff1; // odd so alignment shows
  localparam logic [7:0] CCR_V = 8'h5a;
  always #5 pclk = ~pclk;
  rie_seq #(.NP(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmi_n(nmi_n), .ext_request_line_n(irq_n), .wake_line_n(wake_n),
    .abrk_req(abrk_req), .sleep_xfer(sleep_xfer), .periph_flag(periph_flag),
    .instr_done(instr_done), .rte_done(rte_done), .rte_mask(rte_mask), .cpu_pc(cpu_pc),
    .cpu_ccr(CCR_V), .stack_pointer(SP_ODD), .cpu_halt(cpu_halt),
    .periph_rst_n(periph_rst_n), .cond_code_mask(cond_code_mask), .vec_fetch(vec_fetch),
    .vector_addr(vector_addr), .load_pc(load_pc), .stack_push(stack_push),
    .stack_addr(stack_addr), .push_data(push_data));
  rie_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .cpu_halt(cpu_halt),
    .stack_push(stack_push), .vec_fetch(vec_fetch), .load_pc(load_pc), .rte_go(rte_go),
    .instr_done(instr_done), .rte_done(rte_done), .rte_mask(rte_mask), .cpu_pc(cpu_pc));
  // ****
  // helpers
  // ****
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // outputs are read right after the edge, before its updates land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // no limit here: only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    check("apb_wait", n, 2);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  task automatic entry(input int src);
    int n;
    n = 0;
    while (stack_push !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check("push_addr", stack_addr, 16'h0fee);
    check("push_pc", push_data, cpu_pc);
    repeat (2) @(posedge pclk);
    check("push_ccr", push_data, {CCR_V, CCR_V});
    check("ccr_addr", stack_addr, 16'h0fec);
    repeat (2) @(posedge pclk);
    check("push_len", stack_push, 1'b0);
    check("vec_fetch", vec_fetch, 1'b1);
    check("vec_addr", vector_addr, INT_VECTOR_BASE + 16'(2 * src));
    check("mask_set", cond_code_mask, 1'b1);
    @(posedge pclk);
    check("vec_2", vec_fetch, 1'b1);
    @(posedge pclk);
    check("load_pc", load_pc, 1'b1);
  endtask
  task automatic ret();
    // a return during stacking would be overwritten by the mask set after it
    repeat (10) @(posedge pclk);
    rte_go <= 1'b1;
    @(posedge pclk);
    rte_go <= 1'b0;
    repeat (2) @(posedge pclk);
    check("mask_back", cond_code_mask, 1'b0);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge pclk);
      check("no_entry", stack_push, 1'b0);
    end
  endtask
  task automatic reset_dut(input int n);
    int k;
    presetn <= 1'b0;
    repeat (n) @(posedge pclk);
    check("halt", cpu_halt, 1'b1);
    check("prst", periph_rst_n, 1'b0);
    check("rst_mask", cond_code_mask, 1'b1);
    presetn <= 1'b1;
    for (k = 0; k < 6 && load_pc !== 1'b1; k++) begin
      @(posedge pclk);
      if (vec_fetch === 1'b1) check("rst_vec", vector_addr, RESET_VECTOR);
    end
    check("rst_load", load_pc, 1'b1);
    check("prst_off", periph_rst_n, 1'b1);
    @(posedge pclk);
    check("halt_off", cpu_halt, 1'b0);
  endtask
  always @(posedge pclk) begin
    if (!presetn) dones = 0;
    else if (instr_done === 1'b1) dones++;
    if (stack_push === 1'b1 && dones < 2) check("early", dones, 2);
  end
  // ****
  // scenarios
  // ****
  initial begin
    int i, s, p;
    logic rise;
    logic [7:0] a;
    logic [31:0] e;
    i = $urandom(32'h9487);
    reset_dut(4);
    nmi_n <= 1'b0; // falls before the first instruction ends, mask still set
    entry(SRC_NMI);
    nmi_n <= 1'b1;
    rdc("flag_rst", OFS_REQ_FLAG, 32'h0);
    rdc("en_rst", OFS_REQ_ENABLE, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    check("unmapped", er, 1'b1);
    apb(1'b1, OFS_PORT_MODE_1, 32'hf);
    apb(1'b1, OFS_PORT_MODE_5, 32'h3f);
    apb(1'b1, OFS_REQ_ENABLE, 32'haf);
    apb(1'b1, OFS_PERIPH_ENABLE, 32'hf);
    ret();
    for (i = 0; i < 15; i++) begin
      rise = 1'($urandom_range(1, 0));
      s = i < 4 ? SRC_REQ0 + i : i < 10 ? SRC_WAKE : i == 10 ? SRC_DXFER : SRC_PERIPH0 + i - 11;
      p = i < 4 ? i : i - 4;
      apb(1'b1, OFS_REQ_EDGE, {28'h0, {4{rise}}});
      apb(1'b1, OFS_WAKE_EDGE, {26'h0, {6{rise}}});
      @(posedge pclk);
      if (i < 4) irq_n[p] <= 1'b0;
      else if (i < 10) wake_n[p] <= 1'b0;
      else if (i == 10) sleep_xfer <= 1'b1;
      else periph_flag[i - 11] <= 1'b1;
      @(posedge pclk);
      sleep_xfer <= 1'b0;
      if (rise && i < 10) begin
        quiet(4);
        irq_n <= 4'hf;
        wake_n <= 6'h3f;
      end
      entry(s);
      irq_n <= 4'hf;
      wake_n <= 6'h3f;
      periph_flag <= 4'h0;
      a = (i < 4 || i == 10) ? OFS_REQ_FLAG : OFS_WAKE_FLAG;
      e = i == 10 ? 32'h80 : 32'h1 << p;
      if (i <= 10) begin
        rdc("flag_set", a, e);
        apb(1'b1, a, 32'h0);
        rdc("flag_clr", a, 32'h0);
      end
      ret();
    end
    apb(1'b1, OFS_REQ_EDGE, 32'h0);
    @(posedge pclk);
    irq_n <= 4'h6; // two pins fall together
    entry(SRC_REQ0);
    irq_n <= 4'hf;
    apb(1'b1, OFS_REQ_FLAG, 32'h8);
    rdc("flag_keep", OFS_REQ_FLAG, 32'h8);
    ret();
    entry(SRC_REQ0 + 3);
    apb(1'b1, OFS_REQ_FLAG, 32'h0);
    ret();
    apb(1'b1, OFS_REQ_ENABLE, 32'ha0);
    @(posedge pclk);
    irq_n <= 4'he;
    quiet(30);
    irq_n <= 4'hf;
    rdc("dis_flag", OFS_REQ_FLAG, 32'h1);
    apb(1'b1, OFS_REQ_FLAG, 32'h0);
    // pin 1 goes low while it is a plain port, then is switched to interrupt use
    apb(1'b1, OFS_PORT_MODE_1, 32'hd);
    irq_n[1] <= 1'b0;
    apb(1'b1, OFS_PORT_MODE_1, 32'hf);
    do @(posedge pclk); while (instr_done !== 1'b1);
    rdc("mode_flag", OFS_REQ_FLAG, 32'h2);
    apb(1'b1, OFS_REQ_FLAG, 32'h0);
    rdc("mode_clr", OFS_REQ_FLAG, 32'h0);
    irq_n <= 4'hf;
    periph_flag <= 4'h1;
    entry(SRC_PERIPH0);
    quiet(30);
    abrk_req <= 1'b1;
    entry(SRC_ABRK);
    abrk_req <= 1'b0;
    rdc("vec_reg", OFS_VECTOR, {16'h0000, INT_VECTOR_BASE + 16'(2 * SRC_ABRK)});
    periph_flag <= 4'h0;
    ret();
    @(posedge pclk);
    reset_dut(RESET_MIN_CYCLES);
    rdc("mode_rst", OFS_PORT_MODE_1, 32'h0);
    rdc("pen_rst", OFS_PERIPH_ENABLE, 32'h0);
    print_verdict();
  end
  // the whole sequence needs little more than a thousand clocks
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule // reset_and_interrupt_exception_seq_test

//--- verif/rie_cpu_model.sv
`timescale 1ns/1ns
module rie_cpu_model (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic cpu_halt, // core held
  input wire logic stack_push, // entry stacking
  input wire logic vec_fetch, // vector read
  input wire logic load_pc, // pc loaded from a vector
  input wire logic rte_go, // bench asks for a return
  output logic instr_done, // end of instruction pulse
  output logic rte_done, // return executed pulse
  output logic rte_mask, // mask popped by the return
  output logic [15:0] cpu_pc // address of next instruction
);
  // ****
  // core timing
  // ****
  int cnt;
  // the core is frozen while the sequencer stacks or fetches a vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3;
      instr_done <= 1'b0;
      rte_done <= 1'b0;
      cpu_pc <= 16'h0100;
    end else begin
      rte_done <= rte_go;
      instr_done <= 1'b0;
      if (load_pc) begin
        cnt <= 10;
      end else if (cpu_halt || stack_push || vec_fetch) begin
        cnt <= cnt;
      end else if (cnt == 0) begin
        instr_done <= 1'b1;
        cpu_pc <= cpu_pc + 16'h0002;
        // the core cannot see acceptance before stacking starts, so a one-state
        // instruction right at acceptance would move the pc under the push
        cnt <= $urandom_range(12, 1);
      end else begin
        cnt <= cnt - 1;
      end
    end
  end
  // handlers always return to an unmasked program
  assign rte_mask = 1'b0;
endmodule // rie_cpu_model
